// >>> design/spi_eeprom_pkg.sv
// ==========================================================
// Shared constants and types of the serial EEPROM port
package spi_eeprom_pkg;
    // ==========================================================
    // Array organisation
    localparam int ADDR_W = 16;           // Byte address width
    localparam int PAGE_BYTES = 128;      // Bytes per write page
    localparam int PAGE_W = 7;            // Bits of the in-page offset
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 40;    // Local clock period
    localparam int T_WRITE_NS = 5_000_000; // Longest programming time
    // Longest time rounds down to whole cycles
    localparam int WRITE_CYCLES_DFLT = T_WRITE_NS / CLK_PERIOD_NS;
    localparam int PG_CNT_W = 20;         // Width of the programming counter
    // ==========================================================
    // Op-code low bits, bit 3 ignored, upper nibble zero
    localparam logic [2:0] SET_WRITE_LATCH_CMD = 3'h6;
    localparam logic [2:0] CLEAR_WRITE_LATCH_CMD = 3'h4;
    localparam logic [2:0] STATUS_READ_CMD = 3'h5;
    localparam logic [2:0] STATUS_WRITE_CMD = 3'h1;
    localparam logic [2:0] ARRAY_READ_CMD = 3'h3;
    localparam logic [2:0] ARRAY_WRITE_CMD = 3'h2;
    // ==========================================================
    // Status byte layout
    localparam int SR_BUSY_BIT = 0;
    localparam int SR_WEL_BIT = 1;
    localparam int SR_BP_LO_BIT = 2;
    localparam int SR_BP_HI_BIT = 3;
    localparam int SR_WPEN_BIT = 7;
    localparam logic [7:0] SR_BUSY_VALUE = 8'hff; // All ones while programming
    // ==========================================================
    // Protection levels
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;
    // ==========================================================
    // Serial pins as seen by the device
    typedef struct packed {
        logic cs_n;    // Chip select, active low
        logic sck;     // Serial clock
        logic si;      // Serial data in
        logic hold_n;  // Suspend, active low
        logic wp_n;    // Write protect, active low
    } spi_pins_t;
    localparam spi_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                       hold_n: 1'b1, wp_n: 1'b1};
    // ==========================================================
    // Serial sequence states, one-hot
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_OPC    = 8'h02,
        ST_ADDR   = 8'h04,
        ST_WDATA  = 8'h08,
        ST_RDATA  = 8'h10,
        ST_SWR    = 8'h20,
        ST_DONE   = 8'h40,
        ST_IGNORE = 8'h80
    } ser_state_t;
endpackage : spi_eeprom_pkg

// >>> design/spi_eeprom_port.sv
//  Behaviour
// - Modes 0 and 3 via edge detection
// - 65,536 bytes, 128-byte write pages
// - Write accepts one byte to full page
// - Programming cycle self-timed, at most 5 ms
// - Quarter, half or whole array write-protected
// - Reset ignores instructions, then standby
// - Reset reassertion abandons sequence, standby
// - All bytes shifted MSB first
// - First eight bits are the op-code
// - Select rise ends; launches write programming
// - Select high: standby, output high impedance
// - Input sampled on serial clock rise
// - Read data changes on serial clock fall
// - Suspend freezes sequence, release resumes it
// - Op-codes decoded with bit 3 ignored
// - Busy accepts only status read
// - Write latch clears at power-up
// - Op-code then 16-bit address and data
`timescale 1ns/1ps
module spi_eeprom_port #(
    parameter int WRITE_CYCLES = spi_eeprom_pkg::WRITE_CYCLES_DFLT
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    // Serial pins from the master
    input wire spi_eeprom_pkg::spi_pins_t spi_in,
    // Serial data out, three-state
    output logic so_out,
    output logic so_oe_out,
    // Status
    output logic busy_out,
    output logic wel_out,
    output logic [1:0] block_protect_level_out
);
    import spi_eeprom_pkg::*;

    // ==========================================================
    // Elaboration checks
    if (WRITE_CYCLES <= PAGE_BYTES || WRITE_CYCLES >= 2 ** PG_CNT_W) begin : g_bad_cycles
        $error("WRITE_CYCLES out of range");
    end

    // ==========================================================
    // Reset release and pin synchronisers
    logic rst_meta;            // First reset stage
    logic rst_n;               // Released reset used everywhere
    spi_pins_t pins_meta;      // First pin stage, read only by second
    spi_pins_t pins;           // Synchronised pins
    logic sck_prev;            // Previous serial clock level
    logic cs_prev;             // Previous select level

    // Reset released through two flops
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pins cross two flops before any logic looks at them
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pins_meta <= PINS_IDLE;
            pins <= PINS_IDLE;
            sck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end else begin
            pins_meta <= spi_in;
            pins <= pins_meta;
            sck_prev <= pins.sck;
            cs_prev <= pins.cs_n;
        end
    end

    // Edge events; idle level of the clock does not matter
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    assign sck_rise = pins.sck && !sck_prev;
    assign sck_fall = !pins.sck && sck_prev;
    assign cs_fall = !pins.cs_n && cs_prev;
    assign cs_rise = pins.cs_n && !cs_prev;

    // ==========================================================
    // Storage
    logic [7:0] mem [2 ** ADDR_W];         // Array, not reset: it is nonvolatile
    logic [7:0] page_buf [PAGE_BYTES];     // Page write buffer
    logic [PAGE_BYTES-1:0] loaded;         // Buffer bytes written this command
    logic [PAGE_BYTES-1:0] next_loaded;

    // ==========================================================
    // Serial sequence state
    ser_state_t state;
    ser_state_t next_state;
    logic [3:0] bit_cnt;          // Bits taken in the current field
    logic [3:0] next_bit_cnt;
    logic [2:0] tx_cnt;           // Bits sent of the current byte
    logic [2:0] next_tx_cnt;
    logic [7:0] shift;            // Receive shifter
    logic [7:0] next_shift;
    logic [ADDR_W-1:0] addr;      // Byte address
    logic [ADDR_W-1:0] next_addr;
    logic [2:0] cmd;              // Decoded op-code bits
    logic [2:0] next_cmd;
    logic armed;                  // Command complete, act on select rise
    logic next_armed;
    logic next_wel;
    logic [1:0] next_bp;
    logic wpen;                   // Hardware protect enable
    logic next_wpen;
    logic next_so;
    logic next_so_oe;
    logic launch;                 // Start programming
    logic launch_array;           // Programming includes the array
    logic buf_we;                 // Store received byte into buffer
    logic [7:0] rx_byte;          // Byte completed by this rising edge
    logic [7:0] status;           // Status byte as read
    logic [7:0] rd_byte;          // Byte being sent

    // ==========================================================
    // Programming engine state
    logic pg_array;
    logic next_pg_array;
    logic [PG_CNT_W-1:0] pg_cnt;
    logic [PG_CNT_W-1:0] next_pg_cnt;
    logic next_busy;
    logic mem_we;
    logic [PAGE_W-1:0] pg_idx;
    assign pg_idx = pg_cnt[PAGE_W-1:0];

    // Protected range for a level
    function automatic logic is_protected(input logic [1:0] lvl, input logic [ADDR_W-1:0] a);
        unique case (lvl)
            BP_QUARTER: is_protected = (a[15:14] == 2'h3);
            BP_HALF: is_protected = a[15];
            BP_ALL: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction : is_protected

    // Status byte; all ones while programming
    always_comb begin
        status = 8'h00;
        status[SR_WEL_BIT] = wel_out;
        status[SR_BP_HI_BIT:SR_BP_LO_BIT] = block_protect_level_out;
        status[SR_WPEN_BIT] = wpen;
        if (busy_out) begin
            status = SR_BUSY_VALUE;
        end
        rd_byte = (cmd == STATUS_READ_CMD) ? status : mem[addr];
    end

    // ==========================================================
    // Serial sequence next values
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_tx_cnt = tx_cnt;
        next_shift = shift;
        next_addr = addr;
        next_cmd = cmd;
        next_armed = armed;
        next_wel = wel_out;
        next_bp = block_protect_level_out;
        next_wpen = wpen;
        next_so = so_out;
        next_so_oe = 1'b0;
        next_loaded = loaded;
        launch = 1'b0;
        launch_array = 1'b0;
        buf_we = 1'b0;
        rx_byte = {shift[6:0], pins.si};
        if (pins.cs_n) begin
            // Deselected: standby, output released
            next_state = ST_IDLE;
            next_armed = 1'b0;
            if (cs_rise && armed) begin
                unique case (cmd)
                    SET_WRITE_LATCH_CMD: next_wel = 1'b1;
                    CLEAR_WRITE_LATCH_CMD: next_wel = 1'b0;
                    STATUS_WRITE_CMD: begin
                        if (wel_out) begin
                            // Hardware protect keeps the status bits
                            if (!(wpen && !pins.wp_n)) begin
                                next_wpen = shift[SR_WPEN_BIT];
                                next_bp = shift[SR_BP_HI_BIT:SR_BP_LO_BIT];
                            end
                            launch = 1'b1;
                            next_wel = 1'b0;
                        end
                    end
                    ARRAY_WRITE_CMD: begin
                        if (wel_out) begin
                            launch = 1'b1;
                            launch_array = 1'b1;
                            next_wel = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end else if (!pins.hold_n) begin
            // Suspended: nothing moves, output released
            next_state = state;
        end else if (state == ST_IDLE) begin
            // Only a falling select starts a command
            if (cs_fall) begin
                next_state = ST_OPC;
                next_bit_cnt = 4'h0;
            end
        end else begin
            next_so_oe = (state == ST_RDATA);
            if (sck_rise) begin
                next_shift = rx_byte;
                next_bit_cnt = bit_cnt + 4'h1;
                unique case (state)
                    ST_OPC: begin
                        if (bit_cnt == 4'h7) begin
                            next_bit_cnt = 4'h0;
                            next_tx_cnt = 3'h0;
                            next_cmd = rx_byte[2:0];
                            next_state = ST_IGNORE;
                            if (rx_byte[7:4] != 4'h0) begin
                                next_state = ST_IGNORE;
                            end else if (busy_out && rx_byte[2:0] != STATUS_READ_CMD) begin
                                next_state = ST_IGNORE;
                            end else begin
                                unique case (rx_byte[2:0])
                                    SET_WRITE_LATCH_CMD, CLEAR_WRITE_LATCH_CMD: begin
                                        next_state = ST_DONE;
                                        next_armed = 1'b1;
                                    end
                                    STATUS_READ_CMD: next_state = ST_RDATA;
                                    STATUS_WRITE_CMD: next_state = ST_SWR;
                                    ARRAY_READ_CMD: next_state = ST_ADDR;
                                    ARRAY_WRITE_CMD: begin
                                        next_state = ST_ADDR;
                                        next_loaded = '0;
                                    end
                                    default: next_state = ST_IGNORE;
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        next_addr = {addr[ADDR_W-2:0], pins.si};
                        if (bit_cnt == 4'hf) begin
                            next_bit_cnt = 4'h0;
                            next_state = (cmd == ARRAY_READ_CMD) ? ST_RDATA : ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt[2:0] == 3'h7) begin
                            next_bit_cnt = 4'h0;
                            buf_we = 1'b1;
                            next_loaded[addr[PAGE_W-1:0]] = 1'b1;
                            next_armed = 1'b1;
                            // Stay within the page
                            next_addr[PAGE_W-1:0] = addr[PAGE_W-1:0] + 7'h01;
                        end
                    end
                    ST_SWR: begin
                        if (bit_cnt == 4'h7) begin
                            next_state = ST_DONE;
                            next_armed = 1'b1;
                        end
                    end
                    ST_DONE: begin
                        // Clocks past the last bit void the command
                        next_state = ST_IGNORE;
                        next_armed = 1'b0;
                    end
                    default: ;
                endcase
            end else if (sck_fall && state == ST_RDATA) begin
                next_so = rd_byte[3'h7 - tx_cnt];
                next_tx_cnt = tx_cnt + 3'h1;
                if (tx_cnt == 3'h7 && cmd == ARRAY_READ_CMD) begin
                    next_addr = addr + 16'h0001;
                end
            end
        end
    end

    // Serial sequence registers; reset returns to standby
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            tx_cnt <= 3'h0;
            shift <= 8'h00;
            addr <= 16'h0000;
            cmd <= 3'h0;
            armed <= 1'b0;
            wel_out <= 1'b0;
            block_protect_level_out <= BP_NONE;
            wpen <= 1'b0;
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
            loaded <= '0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            tx_cnt <= next_tx_cnt;
            shift <= next_shift;
            addr <= next_addr;
            cmd <= next_cmd;
            armed <= next_armed;
            wel_out <= next_wel;
            block_protect_level_out <= next_bp;
            wpen <= next_wpen;
            so_out <= next_so;
            so_oe_out <= next_so_oe;
            loaded <= next_loaded;
        end
    end

    // ==========================================================
    // Programming engine: commits one buffered byte per cycle, then waits
    always_comb begin
        next_busy = busy_out;
        next_pg_cnt = pg_cnt;
        next_pg_array = pg_array;
        mem_we = 1'b0;
        if (launch) begin
            next_busy = 1'b1;
            next_pg_cnt = '0;
            next_pg_array = launch_array;
        end else if (busy_out) begin
            if (pg_array && pg_cnt < PG_CNT_W'(PAGE_BYTES) && loaded[pg_idx] &&
                !is_protected(block_protect_level_out, {addr[ADDR_W-1:PAGE_W], pg_idx})) begin
                mem_we = 1'b1;
            end
            if (pg_cnt == PG_CNT_W'(WRITE_CYCLES - 1)) begin
                next_busy = 1'b0;
            end else begin
                next_pg_cnt = pg_cnt + 1'b1;
            end
        end
    end

    // Programming registers
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            busy_out <= 1'b0;
            pg_cnt <= '0;
            pg_array <= 1'b0;
        end else begin
            busy_out <= next_busy;
            pg_cnt <= next_pg_cnt;
            pg_array <= next_pg_array;
        end
    end

    // Buffer and array writes
    always_ff @(posedge ref_clk_in) begin
        if (buf_we) begin
            page_buf[addr[PAGE_W-1:0]] <= rx_byte;
        end
        if (mem_we) begin
            mem[{addr[ADDR_W-1:PAGE_W], pg_idx}] <= page_buf[pg_idx];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    int busy_len;   // Cycles of the current busy period
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_out ? busy_len + 1 : 0;
        end
    end

    AST_BUSY_BOUNDED: assert property (busy_len <= WRITE_CYCLES)
        else $error("programming exceeds its time");
    AST_LAUNCH_BUSY: assert property (launch |=> busy_out && !wel_out)
        else $error("launch did not start programming");
    AST_DESELECT_HIZ: assert property (pins.cs_n |=> !so_oe_out && state == ST_IDLE)
        else $error("output driven while deselected");
    AST_WEL_AFTER_RESET: assert property ($rose(rst_n) |-> !wel_out && state == ST_IDLE)
        else $error("latch or state not cleared by reset");
    AST_BUSY_IGNORES: assert property (state == ST_OPC && sck_rise && bit_cnt == 4'h7 &&
        !pins.cs_n && pins.hold_n && busy_out && rx_byte[2:0] != STATUS_READ_CMD
        |=> state == ST_IGNORE)
        else $error("command accepted while busy");
    AST_PAGE_WRAP: assert property (buf_we && addr[PAGE_W-1:0] == 7'h7f
        |=> addr[PAGE_W-1:0] == 7'h00 && addr[ADDR_W-1:PAGE_W] == $past(addr[ADDR_W-1:PAGE_W]))
        else $error("page address did not wrap");
    AST_READ_INC: assert property (state == ST_RDATA && cmd == ARRAY_READ_CMD &&
        sck_fall && tx_cnt == 3'h7 && !pins.cs_n && pins.hold_n
        |=> addr == $past(addr) + 16'h0001)
        else $error("read address did not advance");
    // Protected ranges spelled out apart from the write path's function
    AST_PROTECTED: assert property (mem_we |-> block_protect_level_out != BP_ALL &&
        !(block_protect_level_out == BP_HALF && addr[ADDR_W-1]) &&
        !(block_protect_level_out == BP_QUARTER && addr[ADDR_W-1:ADDR_W-2] == 2'h3))
        else $error("write to protected block");
    AST_SO_ON_FALL: assert property ($changed(so_out) |-> $past(sck_fall))
        else $error("output changed off a falling edge");
    AST_HOLD_FREEZE: assert property (!pins.hold_n && !pins.cs_n && state != ST_IDLE
        |=> $stable(state) && $stable(bit_cnt) && $stable(addr) && !so_oe_out)
        else $error("sequence moved while suspended");

    COV_READ: cover property (state == ST_RDATA && cmd == ARRAY_READ_CMD && tx_cnt == 3'h7);
    COV_WRITE: cover property (launch && launch_array);
    COV_STATUS_BUSY: cover property (busy_out && state == ST_RDATA && cmd == STATUS_READ_CMD);
    COV_HOLD: cover property (!pins.hold_n && state == ST_WDATA);
endmodule : spi_eeprom_port

// >>> tb/spi_master_model.sv
`timescale 1ns/1ps
// ==========================================================
// Bus master partner: mode 0 or 3, sck of 8 ref clocks
module spi_master_model (
    // Clock
    input wire logic ref_clk_in,
    // Device answer
    input wire logic so_in,
    input wire logic so_oe_in,
    // Serial pins
    output spi_eeprom_pkg::spi_pins_t spi_out
);
    import spi_eeprom_pkg::*;
    logic cpol = 1'b0; // Clock idle level, 1 for mode 3
    // Idle pins from time zero, sck at its idle level outside frames
    initial spi_out = PINS_IDLE;
    // Wait whole ref clocks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick
    // Select edge, then settle time for the synchronisers
    task automatic sel(input logic v);
        @(posedge ref_clk_in);
        spi_out.cs_n <= v;
        tick(5);
        // Idle level only while deselected; a frame starts with sck low
        spi_out.sck <= v & cpol;
    endtask : sel
    // Suspend, only moved while sck is low
    task automatic hold(input logic v);
        @(posedge ref_clk_in);
        spi_out.hold_n <= v;
        tick(5);
    endtask : hold
    // Write protect pin, moved only while deselected
    task automatic wp(input logic v);
        @(posedge ref_clk_in);
        spi_out.wp_n <= v;
        tick(5);
    endtask : wp
    // Clock mode, changed only while deselected
    task automatic mode(input logic c);
        @(posedge ref_clk_in);
        cpol = c;
        spi_out.sck <= c;
        tick(5);
    endtask : mode
    // One byte each way, MSB first
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge ref_clk_in);
            spi_out.si <= tx[i];
            tick(3);
            spi_out.sck <= 1'b1;
            tick(2);
            // Released line reads inverted, so it never matches by luck
            #1 rx[i] = so_oe_in ? so_in : ~so_in;
            tick(2);
            spi_out.sck <= 1'b0;
        end
    endtask : xfer
endmodule : spi_master_model

// >>> tb/spi_eeprom_port_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the serial EEPROM port
module spi_eeprom_port_tb;
    import spi_eeprom_pkg::*;
    localparam int WCYC = 200; // Short programming time
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    spi_pins_t spi_pins;
    logic so_out, so_oe_out, busy_out, wel_out;
    logic [1:0] block_protect_level_out;
    logic [7:0] rx;
    int fail_count = 0;
    int check_count = 0;
    int busy_run = 0; // Length of the running busy period
    // Busy length counted apart from the waiting task
    always @(posedge ref_clk_in) begin
        busy_run <= (busy_out === 1'b1) ? busy_run + 1 : 0;
    end
    // ==========================================================
    // Device and partner
    spi_eeprom_port #(.WRITE_CYCLES(WCYC)) u_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .spi_in(spi_pins), .so_out(so_out), .so_oe_out(so_oe_out), .busy_out(busy_out),
        .wel_out(wel_out), .block_protect_level_out(block_protect_level_out));
    spi_master_model u_master (.ref_clk_in(ref_clk_in), .so_in(so_out),
        .so_oe_in(so_oe_out), .spi_out(spi_pins));
    initial forever #20 ref_clk_in = ~ref_clk_in;
    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    // Whole frame; the last byte seen lands in rx
    task automatic frame(input logic [7:0] q[$]);
        u_master.sel(1'b0);
        foreach (q[i]) u_master.xfer(q[i], rx);
        u_master.sel(1'b1);
    endtask : frame
    // Bounded wait for the end of programming, length checked
    task automatic wait_idle;
        int n = 0;
        while (busy_out !== 1'b0 && n < 2000) begin
            @(posedge ref_clk_in);
            n++;
        end
        if (n >= 2000) begin
            chk(8'h00, 8'h01);
            give_verdict();
        end else begin
            chk(8'(WCYC), 8'(busy_run));
        end
    endtask : wait_idle
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk(8'h00, {4'h0, so_oe_out, busy_out, wel_out, 1'b0});
        chk(8'h00, {6'h00, block_protect_level_out});
    endtask : t_reset
    task automatic t_latch;
        frame('{8'h02, 8'h00, 8'h00, 8'h55});
        chk(8'h00, {7'h00, busy_out});
        frame('{8'h06});
        chk(8'h01, {7'h00, wel_out});
        frame('{8'h0C});
        chk(8'h00, {7'h00, wel_out});
    endtask : t_latch
    task automatic t_mode3;
        u_master.mode(1'b1);
        frame('{8'h06});
        frame('{8'h05, 8'h00});
        chk(8'h02, rx);
        frame('{8'h04});
        chk(8'h00, {7'h00, wel_out});
        u_master.mode(1'b0);
    endtask : t_mode3
    task automatic t_page;
        frame('{8'h06});
        frame('{8'h02, 8'h10, 8'h7E, 8'hA1, 8'hA2, 8'hA3});
        chk(8'h02, {6'h00, busy_out, wel_out});
        frame('{8'h05, 8'h00});
        chk(8'hFF, rx);
        wait_idle();
        u_master.sel(1'b0);
        u_master.xfer(8'h03, rx);
        u_master.xfer(8'h10, rx);
        u_master.xfer(8'h7E, rx);
        u_master.xfer(8'h00, rx);
        chk(8'hA1, rx);
        u_master.hold(1'b0);
        chk(8'h00, {7'h00, so_oe_out});
        u_master.hold(1'b1);
        u_master.xfer(8'h00, rx);
        chk(8'hA2, rx);
        u_master.sel(1'b1);
        chk(8'h00, {7'h00, so_oe_out});
        frame('{8'h03, 8'h10, 8'h00, 8'h00});
        chk(8'hA3, rx);
    endtask : t_page
    task automatic t_protect;
        logic [1:0] lv[4] = '{BP_NONE, BP_QUARTER, BP_HALF, BP_ALL};
        foreach (lv[i]) begin
            frame('{8'h06});
            frame('{8'h01, {4'h0, lv[i], 2'b00}});
            // Set latch while busy must be ignored
            frame('{8'h06});
            chk(8'h00, {7'h00, wel_out});
            wait_idle();
            chk({6'h00, lv[i]}, {6'h00, block_protect_level_out});
            // Only the unprotected pass may change the top quarter
            frame('{8'h06});
            frame('{8'h02, 8'hC0, 8'h00, 8'h30 + 8'(i)});
            wait_idle();
            frame('{8'h03, 8'hC0, 8'h00, 8'h00});
            chk(8'h30, rx);
        end
        // Hardware protect: status bits frozen, busy cycle still runs
        frame('{8'h06});
        frame('{8'h01, 8'h80});
        wait_idle();
        u_master.wp(1'b0);
        frame('{8'h06});
        frame('{8'h01, 8'h84});
        wait_idle();
        frame('{8'h05, 8'h00});
        chk(8'h80, rx);
        u_master.wp(1'b1);
    endtask : t_protect
    task automatic t_reset_mid;
        frame('{8'h06});
        u_master.sel(1'b0);
        u_master.xfer(8'h02, rx);
        u_master.xfer(8'h10, rx);
        u_master.xfer(8'h00, rx);
        u_master.xfer(8'h5A, rx);
        rstn_in <= 1'b0;
        u_master.sel(1'b1);
        rstn_in <= 1'b1;
        u_master.tick(8);
        chk(8'h00, {6'h00, busy_out, wel_out});
        frame('{8'h03, 8'h10, 8'h00, 8'h00});
        chk(8'hA3, rx);
    endtask : t_reset_mid
    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        u_master.tick(8);
        t_reset();
        t_latch();
        t_mode3();
        t_page();
        t_protect();
        t_reset_mid();
        give_verdict();
    end
endmodule : spi_eeprom_port_tb
